// *** bench/sclirq_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
// bus answer and interrupt line checks seen at the top ports
module sclirq_assertions (
    input wire logic                        core_clk,       // system clock
    input wire logic                        reset,          // sync, high
    input wire sclirq_pkg::sclirq_axi_req_s axiReq,         // bus requests
    input wire sclirq_pkg::sclirq_axi_rsp_s axiRsp,         // bus answers
    input wire logic                        masterIrqEvent, // raw event
    input wire logic                        irqOut,         // irq line
    input wire logic                        sclOut,         // serial clock
    input wire logic                        sclTick         // period strobe
);
    logic [7:0] awAddr_r; // captured write address
    logic [1:0] wBits_r;  // captured strobe lane 0 and data bit 0
    logic       maskQ_r;  // mask as of the last acknowledged write
    // shadow the mask from acknowledged writes only
    always_ff @(posedge core_clk) begin
        if (reset) begin
            awAddr_r <= 8'h00;
            wBits_r  <= 2'h0;
            maskQ_r  <= 1'b0;
        end else begin
            if (axiReq.awvalid && axiRsp.awready) awAddr_r <= axiReq.awaddr;
            if (axiReq.wvalid && axiRsp.wready)
                wBits_r <= {axiReq.wstrb[0], axiReq.wdata[0]};
            if (axiRsp.bvalid && axiReq.bready && wBits_r[1] &&
                awAddr_r == sclirq_pkg::OFS_MASK) maskQ_r <= wBits_r[0];
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    sequence wrTaken;
        axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready;
    endsequence
    sequence maskOffQuiet;
        !maskQ_r && !axiRsp.bvalid;
    endsequence
    sequence maskOnQuiet;
        maskQ_r && !axiRsp.bvalid;
    endsequence
    wr_answer_a: assert property (
        wrTaken |=> !axiRsp.bvalid ##1 axiRsp.bvalid)
        else $error("write response not on second cycle");
    rd_answer_a: assert property (
        axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid)
        else $error("read response late");
    b_once_a: assert property (
        axiRsp.bvalid && axiReq.bready |=> !axiRsp.bvalid)
        else $error("write response repeated");
    upper_zero_a: assert property (
        axiRsp.rvalid |-> axiRsp.rdata[31:8] == 24'h0)
        else $error("reserved read bits set");
    irq_block_a: assert property (
        maskOffQuiet ##1 maskOffQuiet |-> !irqOut)
        else $error("interrupt passed while masked");
    irq_pass_a: assert property (
        masterIrqEvent ##0 maskOnQuiet ##1 maskOnQuiet |=> irqOut)
        else $error("interrupt not forwarded");
    irq_hold_a: assert property (
        irqOut && !axiRsp.bvalid |=> irqOut)
        else $error("interrupt dropped without clear");
    tick_space_a: assert property (sclTick |=> !sclTick [*8])
        else $error("serial clock period too short");
endmodule : sclirq_assertions
bind sclirq_top sclirq_assertions chk_u (
    .core_clk(core_clk), .reset(reset), .axiReq(axiReq), .axiRsp(axiRsp),
    .masterIrqEvent(masterIrqEvent), .irqOut(irqOut), .sclOut(sclOut),
    .sclTick(sclTick));
`default_nettype wire

// *** bench/sclirq_bus_slave.sv ***
`timescale 1ns/100ps
`default_nettype none
// serial bus slave side: measures the clock it is given
module sclirq_bus_slave (
    input  wire logic        core_clk,  // system clock
    input  wire logic        reset,     // sync, high
    input  wire logic        sclOut,    // serial clock from master
    input  wire logic        sclTick,   // period strobe from master
    output logic      [15:0] lowLen,    // last low run in cycles
    output logic      [15:0] highLen,   // last high run in cycles
    output logic      [15:0] periodLen  // last strobe spacing
);
    logic [15:0] runCnt;  // cycles at the present level
    logic [15:0] tickCnt; // cycles since the last strobe
    logic        sclPrev; // level one cycle ago
    always_ff @(posedge core_clk) begin
        sclPrev <= sclOut;
        tickCnt <= sclTick ? 16'h1 : tickCnt + 16'h1;
        if (sclTick) periodLen <= tickCnt;
        if (reset) runCnt <= 16'h1;
        else if (sclOut == sclPrev) runCnt <= runCnt + 16'h1;
        else begin
            runCnt <= 16'h1;
            if (sclOut) lowLen <= runCnt;
            else highLen <= runCnt;
        end
    end
endmodule : sclirq_bus_slave
`default_nettype wire

// *** bench/testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
// register, serial clock and interrupt tests
module testbench;
    localparam logic [7:0] DIV = sclirq_pkg::OFS_DIVIDER; // divider
    localparam logic [7:0] MSK = sclirq_pkg::OFS_MASK;    // mask
    localparam logic [7:0] RAW = sclirq_pkg::OFS_RAW;     // raw status
    localparam logic [7:0] MSD = sclirq_pkg::OFS_MASKED;  // masked status
    logic                        core_clk;       // system clock
    logic                        reset;          // sync, high
    sclirq_pkg::sclirq_axi_req_s req;            // bus requests
    sclirq_pkg::sclirq_axi_rsp_s rsp;            // bus answers
    logic                        masterIrqEvent; // raw event
    logic                        irqOut;         // irq line
    logic                        sclOut;         // serial clock
    logic                        sclTick;        // period strobe
    logic [15:0] lowLen, highLen, periodLen;     // slave measurements
    int          errCount, nCompared;            // verdict counters
    logic [31:0] rdVal, expLen;                  // scratch
    logic [1:0]  respVal;                        // scratch response
    logic [7:0]  divTab [3] = '{8'h01, 8'h02, 8'hff}; // divider cases
    sclirq_top dut_u (.core_clk(core_clk), .reset(reset), .axiReq(req),
        .axiRsp(rsp), .masterIrqEvent(masterIrqEvent), .irqOut(irqOut),
        .sclOut(sclOut), .sclTick(sclTick));
    sclirq_bus_slave slave_u (.core_clk(core_clk), .reset(reset),
        .sclOut(sclOut), .sclTick(sclTick), .lowLen(lowLen),
        .highLen(highLen), .periodLen(periodLen));
    // clock of 4 ns
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // compare and count
    task automatic check(input string what, input logic [31:0] seen, exp);
        nCompared++;
        if (seen !== exp) begin
            errCount++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // verdict and end of run
    task automatic printVerdict();
        if (errCount == 0 && nCompared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : printVerdict
    // one write, both channels offered together
    task automatic wrCheck(input logic [7:0] a, input logic [31:0] d,
                           input logic [1:0] er);
        logic awHit, wHit, bHit;
        @(posedge core_clk);
        req.awaddr <= a; req.awvalid <= 1'b1; req.wdata <= d;
        req.wstrb <= 4'hf; req.wvalid <= 1'b1; req.bready <= 1'b1;
        do begin
            @(negedge core_clk);
            awHit = req.awvalid && rsp.awready;
            wHit = req.wvalid && rsp.wready;
            bHit = rsp.bvalid;
            respVal = rsp.bresp;
            @(posedge core_clk);
            if (awHit) req.awvalid <= 1'b0;
            if (wHit) req.wvalid <= 1'b0;
        end while (bHit !== 1'b1);
        req.bready <= 1'b0;
        check("bresp", {30'h0, respVal}, {30'h0, er});
    endtask : wrCheck
    // one read, returns data
    task automatic busRead(input logic [7:0] a, input logic [1:0] er);
        logic arHit, rHit;
        @(posedge core_clk);
        req.araddr <= a; req.arvalid <= 1'b1; req.rready <= 1'b1;
        do begin
            @(negedge core_clk);
            arHit = req.arvalid && rsp.arready;
            rHit = rsp.rvalid;
            rdVal = rsp.rdata;
            respVal = rsp.rresp;
            @(posedge core_clk);
            if (arHit) req.arvalid <= 1'b0;
        end while (rHit !== 1'b1);
        req.rready <= 1'b0;
        check("rresp", {30'h0, respVal}, {30'h0, er});
    endtask : busRead
    // read and compare
    task automatic rdCheck(input logic [7:0] a, input logic [31:0] e);
        busRead(a, (a > 8'h1c || a < DIV) ? 2'h2 : 2'h0);
        check("rdata", rdVal, e);
    endtask : rdCheck
    // raise the event for one cycle and let it land
    task automatic pulseEvent();
        @(posedge core_clk) masterIrqEvent <= 1'b1;
        @(posedge core_clk) masterIrqEvent <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask : pulseEvent
    // hang guard
    initial begin
        repeat (60000) @(posedge core_clk);
        errCount++;
        printVerdict();
    end
    // main sequence
    initial begin
        req = '0; reset = 1'b1; masterIrqEvent = 1'b0;
        errCount = 0; nCompared = 0;
        repeat (8) @(posedge core_clk);
        reset <= 1'b0;
        rdCheck(DIV, 32'h1);
        rdCheck(MSK, 32'h0);
        rdCheck(RAW, 32'h0);
        rdCheck(MSD, 32'h0);
        wrCheck(DIV, 32'hffffffff, 2'h0);
        rdCheck(DIV, 32'hff);
        wrCheck(MSK, 32'hffffffff, 2'h0);
        rdCheck(MSK, 32'h1);
        wrCheck(8'h40, 32'h1, 2'h2);
        rdCheck(8'h40, 32'h0);
        wrCheck(MSK, 32'h0, 2'h0);
        foreach (divTab[i]) begin
            wrCheck(DIV, {24'h0, divTab[i]}, 2'h0);
            repeat (3) @(posedge sclTick);
            @(negedge core_clk);
            expLen = 32'd2 * (32'd1 + divTab[i]);
            check("low", {16'h0, lowLen}, expLen * 6);
            check("high", {16'h0, highLen}, expLen * 4);
            check("period", {16'h0, periodLen}, expLen * 10);
        end
        pulseEvent();
        @(negedge core_clk);
        check("irq masked", {31'h0, irqOut}, 32'h0);
        rdCheck(RAW, 32'h1);
        rdCheck(MSD, 32'h0);
        busRead(MSK, 2'h0);
        wrCheck(MSK, (rdVal & 32'hfffffffe) | 32'h1, 2'h0);
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        check("irq on", {31'h0, irqOut}, 32'h1);
        rdCheck(MSD, 32'h1);
        // a zero written to the clear register changes nothing
        wrCheck(sclirq_pkg::OFS_CLEAR, 32'h0, 2'h0);
        rdCheck(RAW, 32'h1);
        wrCheck(RAW, 32'h0, 2'h0);
        rdCheck(RAW, 32'h1);
        rdCheck(sclirq_pkg::OFS_CLEAR, 32'h0);
        wrCheck(sclirq_pkg::OFS_CLEAR, 32'h1, 2'h0);
        rdCheck(RAW, 32'h0);
        @(negedge core_clk);
        check("irq cleared", {31'h0, irqOut}, 32'h0);
        pulseEvent();
        @(negedge core_clk);
        check("irq again", {31'h0, irqOut}, 32'h1);
        wrCheck(MSK, 32'h0, 2'h0);
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        check("irq blocked", {31'h0, irqOut}, 32'h0);
        rdCheck(RAW, 32'h1);
        printVerdict();
    end
endmodule : testbench
`default_nettype wire

// *** src/sclirq_clkgen.sv ***
`timescale 1ns/100ps
`default_nettype none
// serial clock generator: low for 6 units, high for 4 units,
// each unit being 2*(1+divider) core clocks
module sclirq_clkgen (
    input  wire logic       core_clk,    // system clock
    input  wire logic       reset,       // synchronous, active high
    input  wire logic [7:0] divValue,    // divider_value field
    output logic            sclOut,      // serial clock level
    output logic            sclTick      // one pulse per serial clock period
);

    logic [sclirq_pkg::PRE_W-1:0]  preCnt_r;    // core clocks within a unit
    logic [sclirq_pkg::UNIT_W-1:0] unitCnt_r;   // unit index in the period
    logic [sclirq_pkg::PRE_W-1:0]  preLast;     // last count of a unit
    logic                          unitEnd;     // final core clock of a unit

    // unit length is 2*(1+divider) core clocks
    assign preLast = sclirq_pkg::PRE_W'({1'b0, divValue} + 9'h001) * 9'h002
                     - 9'h001;
    assign unitEnd = (preCnt_r >= preLast);

    // prescaler; a new divider takes hold at once, in the unit in progress
    always_ff @(posedge core_clk) begin
        if (reset) begin
            preCnt_r <= '0;
        end else if (unitEnd) begin
            preCnt_r <= '0;
        end else begin
            preCnt_r <= preCnt_r + 9'h001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            unitCnt_r <= '0;
        end else if (unitEnd) begin
            if (unitCnt_r == sclirq_pkg::UNIT_W'(sclirq_pkg::TOTAL_UNITS - 1))
            begin
                unitCnt_r <= '0;
            end else begin
                unitCnt_r <= unitCnt_r + 4'h1;
            end
        end
    end

    // low six units, then high four
    always_ff @(posedge core_clk) begin
        if (reset) begin
            sclOut  <= 1'b0;
            sclTick <= 1'b0;
        end else begin
            sclOut  <= (unitCnt_r >=
                        sclirq_pkg::UNIT_W'(sclirq_pkg::LOW_UNITS));
            sclTick <= unitEnd && (unitCnt_r ==
                        sclirq_pkg::UNIT_W'(sclirq_pkg::TOTAL_UNITS - 1));
        end
    end

endmodule : sclirq_clkgen
`default_nettype wire

// *** src/sclirq_pkg.sv ***
// shared constants and bus carriers for the serial clock timer slice
package sclirq_pkg;

    // bus geometry
    localparam int ADDR_W = 8;                       // byte address width
    localparam int DATA_W = 32;                      // bus data width

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_DIVIDER  = 8'h0c;  // divider_value
    localparam logic [ADDR_W-1:0] OFS_MASK     = 8'h10;  // mask_enable_bit
    localparam logic [ADDR_W-1:0] OFS_RAW      = 8'h14;  // raw_pending_bit
    localparam logic [ADDR_W-1:0] OFS_MASKED   = 8'h18;  // masked_pending_bit
    localparam logic [ADDR_W-1:0] OFS_CLEAR    = 8'h1c;  // master_irq_clear

    // field layout and reset values
    localparam int DIV_MSB   = 7;                    // divider field 7:0
    localparam int PEND_BIT  = 0;                    // single-bit fields at 0
    localparam logic [7:0] DIV_RESET  = 8'h01;       // divider after reset
    localparam logic       MASK_RESET = 1'b0;        // mask after reset

    // serial clock shape in units
    localparam int LOW_UNITS   = 6;                  // serial_clock_low_units
    localparam int HIGH_UNITS  = 4;                  // serial_clock_high_units
    localparam int TOTAL_UNITS = LOW_UNITS + HIGH_UNITS;
    localparam int UNIT_W      = 4;                  // unit counter width
    localparam int PRE_W       = 9;                  // last count 2*(1+255)-1

    // bus response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // requests from the bus master
    typedef struct packed {
        logic [ADDR_W-1:0]   awaddr;
        logic                awvalid;
        logic [DATA_W-1:0]   wdata;
        logic [DATA_W/8-1:0] wstrb;
        logic                wvalid;
        logic                bready;
        logic [ADDR_W-1:0]   araddr;
        logic                arvalid;
        logic                rready;
    } sclirq_axi_req_s;

    // answers to the bus master
    typedef struct packed {
        logic                awready;
        logic                wready;
        logic                bvalid;
        logic [1:0]          bresp;
        logic                arready;
        logic                rvalid;
        logic [DATA_W-1:0]   rdata;
        logic [1:0]          rresp;
    } sclirq_axi_rsp_s;

endpackage : sclirq_pkg

// *** src/sclirq_top.sv ***
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - serial clock period from divider, 6 low/4 high
// - 8-bit divider at 0x00c, resets to one
// - mask bit 0 at 0x010, resets zero
// - mask gates raw interrupt onto interrupt line
// - raw status at 0x014 ignores mask
// - masked status at 0x018 is raw and mask
// - writing one to clear register bit 0 clears raw status
module sclirq_top (
    input  wire logic                        core_clk,       // system clock
    input  wire logic                        reset,          // sync, high
    input  wire sclirq_pkg::sclirq_axi_req_s axiReq,         // bus requests
    output sclirq_pkg::sclirq_axi_rsp_s      axiRsp,         // bus answers
    input  wire logic                        masterIrqEvent, // raw event pulse
    output logic                             irqOut,         // to controller
    output logic                             sclOut,         // serial clock
    output logic                             sclTick         // period strobe
);

    // register state
    logic [7:0]  divValue_r;        // divider_value
    logic        maskEnable_r;      // mask_enable_bit
    logic        rawPending_r;      // raw_pending_bit
    logic        maskedPending;     // masked_pending_bit

    // write channel state
    logic                          awHeld_r;   // address captured
    logic                          wHeld_r;    // data captured
    logic [sclirq_pkg::ADDR_W-1:0] awAddr_r;   // captured address
    logic [31:0]                   wData_r;    // captured data
    logic [3:0]                    wStrb_r;    // captured strobes
    logic                          doWrite;    // both halves held, no answer
    logic                          wrHit;      // address is mapped

    // read side
    logic [31:0] rdData;            // decoded read data
    logic        rdHit;             // read address is mapped

    assign maskedPending = rawPending_r & maskEnable_r;
    assign doWrite       = awHeld_r && wHeld_r && !axiRsp.bvalid;

    // write address decode
    always_comb begin
        unique case (awAddr_r)
            sclirq_pkg::OFS_DIVIDER,
            sclirq_pkg::OFS_MASK,
            sclirq_pkg::OFS_RAW,
            sclirq_pkg::OFS_MASKED,
            sclirq_pkg::OFS_CLEAR:   wrHit = 1'b1;
            default:                 wrHit = 1'b0;
        endcase
    end

    // address channel: take once, hold until the answer is accepted
    always_ff @(posedge core_clk) begin
        if (reset) begin
            awHeld_r       <= 1'b0;
            awAddr_r       <= '0;
            axiRsp.awready <= 1'b1;
        end else if (axiReq.awvalid && axiRsp.awready) begin
            awHeld_r       <= 1'b1;
            awAddr_r       <= axiReq.awaddr;
            axiRsp.awready <= 1'b0;
        end else if (axiRsp.bvalid && axiReq.bready) begin
            awHeld_r       <= 1'b0;
            axiRsp.awready <= 1'b1;
        end
    end

    // data channel: independent of the address channel
    always_ff @(posedge core_clk) begin
        if (reset) begin
            wHeld_r       <= 1'b0;
            wData_r       <= '0;
            wStrb_r       <= '0;
            axiRsp.wready <= 1'b1;
        end else if (axiReq.wvalid && axiRsp.wready) begin
            wHeld_r       <= 1'b1;
            wData_r       <= axiReq.wdata;
            wStrb_r       <= axiReq.wstrb;
            axiRsp.wready <= 1'b0;
        end else if (axiRsp.bvalid && axiReq.bready) begin
            wHeld_r       <= 1'b0;
            axiRsp.wready <= 1'b1;
        end
    end

    // write response, error on an unmapped address
    always_ff @(posedge core_clk) begin
        if (reset) begin
            axiRsp.bvalid <= 1'b0;
            axiRsp.bresp  <= sclirq_pkg::RESP_OKAY;
        end else if (doWrite) begin
            axiRsp.bvalid <= 1'b1;
            axiRsp.bresp  <= wrHit ? sclirq_pkg::RESP_OKAY
                                   : sclirq_pkg::RESP_SLVERR;
        end else if (axiReq.bready) begin
            axiRsp.bvalid <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            divValue_r <= sclirq_pkg::DIV_RESET;
        end else if (doWrite && wStrb_r[0] &&
                     awAddr_r == sclirq_pkg::OFS_DIVIDER) begin
            divValue_r <= wData_r[sclirq_pkg::DIV_MSB:0];
        end
    end

    // mask bit, upper bits not stored
    always_ff @(posedge core_clk) begin
        if (reset) begin
            maskEnable_r <= sclirq_pkg::MASK_RESET;
        end else if (doWrite && wStrb_r[0] &&
                     awAddr_r == sclirq_pkg::OFS_MASK) begin
            maskEnable_r <= wData_r[sclirq_pkg::PEND_BIT];
        end
    end

    // clear by writing one; a new event wins over the clear
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rawPending_r <= 1'b0;
        end else if (masterIrqEvent) begin
            rawPending_r <= 1'b1;
        end else if (doWrite && wStrb_r[0] &&
                     awAddr_r == sclirq_pkg::OFS_CLEAR &&
                     wData_r[sclirq_pkg::PEND_BIT]) begin
            rawPending_r <= 1'b0;
        end
    end

    // forward only while the mask bit is set
    always_ff @(posedge core_clk) begin
        if (reset) begin
            irqOut <= 1'b0;
        end else begin
            irqOut <= maskedPending;
        end
    end

    // read decode; clear register is write-only and reads zero
    always_comb begin
        rdData = '0;
        rdHit  = 1'b1;
        unique case (axiReq.araddr)
            sclirq_pkg::OFS_DIVIDER: begin
                rdData[sclirq_pkg::DIV_MSB:0] = divValue_r;
            end
            sclirq_pkg::OFS_MASK: begin
                rdData[sclirq_pkg::PEND_BIT] = maskEnable_r;
            end
            sclirq_pkg::OFS_RAW: begin
                rdData[sclirq_pkg::PEND_BIT] = rawPending_r;
            end
            sclirq_pkg::OFS_MASKED: begin
                rdData[sclirq_pkg::PEND_BIT] = maskedPending;
            end
            sclirq_pkg::OFS_CLEAR: begin
                rdData = '0;
            end
            default: begin
                rdHit = 1'b0;
            end
        endcase
    end

    // read channel: one read at a time, answer the next edge
    always_ff @(posedge core_clk) begin
        if (reset) begin
            axiRsp.arready <= 1'b1;
            axiRsp.rvalid  <= 1'b0;
            axiRsp.rdata   <= '0;
            axiRsp.rresp   <= sclirq_pkg::RESP_OKAY;
        end else if (axiReq.arvalid && axiRsp.arready) begin
            axiRsp.arready <= 1'b0;
            axiRsp.rvalid  <= 1'b1;
            axiRsp.rdata   <= rdData;
            axiRsp.rresp   <= rdHit ? sclirq_pkg::RESP_OKAY
                                    : sclirq_pkg::RESP_SLVERR;
        end else if (axiRsp.rvalid && axiReq.rready) begin
            axiRsp.arready <= 1'b1;
            axiRsp.rvalid  <= 1'b0;
        end
    end

    // serial clock timing from the divider
    sclirq_clkgen u_clkgen (
        .core_clk (core_clk),
        .reset    (reset),
        .divValue (divValue_r),
        .sclOut   (sclOut),
        .sclTick  (sclTick)
    );

endmodule : sclirq_top
`default_nettype wire
